//--- hdl/sacb_pkg.sv
// Shared constants of the converter control and bus port
package sacb_pkg;
   localparam int          DATA_W        = 8;
   localparam int          IDX_W         = 3;
   localparam int          APB_AW        = 8;
   localparam int          NUM_EV        = 3;
   // Register byte offsets
   localparam logic [7:0]  OFF_CTRL      = 8'h00;
   localparam logic [7:0]  OFF_STATUS    = 8'h04;
   localparam logic [7:0]  OFF_RESULT    = 8'h08;
   localparam logic [7:0]  OFF_INT_STAT  = 8'h0c;
   localparam logic [7:0]  OFF_INT_MASK  = 8'h10;
   // Field positions
   localparam int          CTRL_START    = 0;
   localparam int          CTRL_PIN_EN   = 1;
   localparam int          ST_BUSY       = 0;
   localparam int          ST_DONE       = 1;
   localparam int          ST_FMT        = 2;
   localparam int          ST_RAW_LSB    = 8;
   localparam int          EV_DONE       = 0;
   localparam int          EV_RESTART    = 1;
   localparam int          EV_START      = 2;
   // Reset and load values
   localparam logic        PIN_EN_RST    = 1'b1;
   localparam logic [2:0]  INT_MASK_RST  = 3'h0;
   localparam logic [7:0]  SAR_CLEAR     = 8'h00;
   localparam logic [7:0]  SAR_FIRST     = 8'h7f;
   localparam logic [2:0]  IDX_MSB       = 3'h7;
   localparam logic [2:0]  IDX_LSB       = 3'h0;
   localparam logic        FMT_OFFSET    = 1'b1;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_CLR   = 5'b00010,
      ST_ARMED = 5'b00100,
      ST_TRIAL = 5'b01000,
      ST_FIN   = 5'b10000
   } sacb_state_type;
endpackage : sacb_pkg

//--- hdl/sacb_pin_sampler.sv
// Pin capture and conversion clock edge detect
`timescale 1ns/1ps
module sacb_pin_sampler (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic conv_clk,
   input  wire logic begin_n,
   input  wire logic unit_enable_n,
   input  wire logic fetch_n,
   input  wire logic output_format_select,
   input  wire logic compare_in,
   output logic      clk_low,
   output logic      clk_rise,
   output logic      begin_low,
   output logic      enable_low,
   output logic      fetch_low,
   output logic      fmt_sel,
   output logic      cmp
);
   logic clk_q;
   logic clk_prev_q;

   // Pins are synchronous to pclk, one register stage is enough
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_q      <= 1'b0;
         clk_prev_q <= 1'b0;
         begin_low  <= 1'b0;
         enable_low <= 1'b0;
         fetch_low  <= 1'b0;
         fmt_sel    <= 1'b0;
         cmp        <= 1'b0;
      end else begin
         clk_q      <= conv_clk;
         clk_prev_q <= clk_q;
         begin_low  <= ~begin_n;
         enable_low <= ~unit_enable_n;
         fetch_low  <= ~fetch_n;
         fmt_sel    <= output_format_select;
         cmp        <= compare_in;
      end
   end

   assign clk_low  = ~clk_q;
   assign clk_rise = clk_q & ~clk_prev_q;
endmodule : sacb_pin_sampler

//--- hdl/sacb_top.sv
// Successive-approximation converter control with pin port and APB registers
`timescale 1ns/1ps
module sacb_top (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [sacb_pkg::APB_AW-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   output logic                             irq,
   input  wire logic                        conv_clk,
   input  wire logic                        unit_enable_n,
   input  wire logic                        begin_n,
   input  wire logic                        fetch_n,
   input  wire logic                        output_format_select,
   input  wire logic                        compare_in,
   output logic      [sacb_pkg::DATA_W-1:0] dac_code,
   output logic      [sacb_pkg::DATA_W-1:0] result_bus,
   output logic                             result_oe,
   output logic                             done_flag_n
);
   import sacb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic [DATA_W-1:0] fmt_code(input logic [DATA_W-1:0] raw,
                                                   input logic             sel);
      fmt_code = (sel == FMT_OFFSET) ? raw : {~raw[DATA_W-1], raw[DATA_W-2:0]};
   endfunction : fmt_code

   function automatic logic reg_hit(input logic [APB_AW-1:0] addr,
                                    input logic [7:0]        off);
      reg_hit = (addr == off);
   endfunction : reg_hit

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   sacb_state_type    state_q;
   sacb_state_type    state_d;
   logic [DATA_W-1:0] sar_q;
   logic [DATA_W-1:0] sar_d;
   logic [DATA_W-1:0] trial_w;
   logic [IDX_W-1:0]  idx_q;
   logic [IDX_W-1:0]  idx_d;
   logic [IDX_W-1:0]  idx_dn_w;
   logic              done_n_q;
   logic              done_n_d;
   logic [DATA_W-1:0] result_q;
   logic              result_oe_q;
   logic              pin_en_q;
   logic              sw_start_q;
   logic [NUM_EV-1:0] int_stat_q;
   logic [NUM_EV-1:0] int_stat_d;
   logic [NUM_EV-1:0] int_mask_q;
   logic [NUM_EV-1:0] ev_w;
   logic              irq_q;
   logic [31:0]       prdata_q;
   logic              pready_q;
   logic              pslverr_q;

   logic              clk_low;
   logic              clk_rise;
   logic              begin_low;
   logic              enable_low;
   logic              fetch_low;
   logic              fmt_sel;
   logic              cmp;

   ////////////////////////////////////////////////////////////////////////////
   // Pin capture

   sacb_pin_sampler u_pins (
      .pclk                 (pclk),
      .presetn              (presetn),
      .conv_clk             (conv_clk),
      .begin_n              (begin_n),
      .unit_enable_n        (unit_enable_n),
      .fetch_n              (fetch_n),
      .output_format_select (output_format_select),
      .compare_in           (compare_in),
      .clk_low              (clk_low),
      .clk_rise             (clk_rise),
      .begin_low            (begin_low),
      .enable_low           (enable_low),
      .fetch_low            (fetch_low),
      .fmt_sel              (fmt_sel),
      .cmp                  (cmp)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Start decode

   wire pin_clear_w  = pin_en_q & begin_low & enable_low & clk_low;
   wire clear_w      = pin_clear_w | sw_start_q;
   wire busy_w       = (state_q == ST_ARMED) | (state_q == ST_TRIAL);
   wire running_w    = busy_w | (state_q == ST_CLR);
   wire read_w       = enable_low & fetch_low;
   wire last_bit_w   = (idx_q == IDX_LSB);

   ////////////////////////////////////////////////////////////////////////////
   // Bit trial datapath

   assign idx_dn_w = idx_q - 3'h1;

   // Decide the bit under trial, present a zero on the next lower one
   genvar gi;
   generate
      for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_trial
         wire on_bit_w   = (idx_q == IDX_W'(gi));
         wire next_bit_w = ~last_bit_w & (idx_dn_w == IDX_W'(gi));
         assign trial_w[gi] = on_bit_w   ? cmp  :
                              next_bit_w ? 1'b0 : sar_q[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_comb begin
      state_d  = state_q;
      sar_d    = sar_q;
      idx_d    = idx_q;
      done_n_d = done_n_q;
      case (state_q)
         ST_IDLE, ST_FIN: begin
            if (clear_w) begin
               state_d  = ST_CLR;
               sar_d    = SAR_CLEAR;
               done_n_d = 1'b1;
            end
         end
         ST_CLR: begin
            if (clear_w) begin
               sar_d = SAR_CLEAR;
            end else begin
               state_d = ST_ARMED;
               sar_d   = SAR_FIRST;
               idx_d   = IDX_MSB;
            end
         end
         ST_ARMED: begin
            if (clear_w) begin
               state_d = ST_CLR;
               sar_d   = SAR_CLEAR;
            end else if (clk_rise) begin
               state_d = ST_TRIAL;
            end
         end
         ST_TRIAL: begin
            if (clear_w) begin
               state_d = ST_CLR;
               sar_d   = SAR_CLEAR;
            end else if (clk_rise) begin
               sar_d = trial_w;
               if (last_bit_w) begin
                  state_d  = ST_FIN;
                  done_n_d = 1'b0;
               end else begin
                  idx_d = idx_dn_w;
               end
            end
         end
         default: begin
            state_d  = ST_IDLE;
            sar_d    = SAR_CLEAR;
            idx_d    = IDX_MSB;
            done_n_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q  <= ST_IDLE;
         sar_q    <= SAR_CLEAR;
         idx_q    <= IDX_MSB;
         done_n_q <= 1'b1;
      end else begin
         state_q  <= state_d;
         sar_q    <= sar_d;
         idx_q    <= idx_d;
         done_n_q <= done_n_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result port

   // Partial codes are visible if read mid conversion, as on the pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_q    <= SAR_CLEAR;
         result_oe_q <= 1'b0;
      end else begin
         result_q    <= fmt_code(sar_q, fmt_sel);
         result_oe_q <= read_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt events

   wire entered_fin_w = (state_d == ST_FIN) & (state_q != ST_FIN);
   wire restart_w     = busy_w & clear_w;
   wire started_w     = (state_q == ST_CLR) & ~clear_w;

   assign ev_w[EV_DONE]    = entered_fin_w;
   assign ev_w[EV_RESTART] = restart_w;
   assign ev_w[EV_START]   = started_w;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave

   wire setup_w    = psel & ~penable;
   wire access_w   = psel & penable & pready_q;
   wire wr_w       = access_w & pwrite;
   wire hit_ctrl_w = reg_hit(paddr, OFF_CTRL);
   wire hit_stat_w = reg_hit(paddr, OFF_STATUS);
   wire hit_res_w  = reg_hit(paddr, OFF_RESULT);
   wire hit_int_w  = reg_hit(paddr, OFF_INT_STAT);
   wire hit_msk_w  = reg_hit(paddr, OFF_INT_MASK);
   wire mapped_w   = hit_ctrl_w | hit_stat_w | hit_res_w | hit_int_w | hit_msk_w;
   wire w1c_w      = wr_w & hit_int_w;

   wire [31:0] ctrl_rd_w = {30'h0, pin_en_q, 1'b0};
   wire [31:0] stat_rd_w = {16'h0, sar_q, 5'h0, fmt_sel, ~done_n_q, running_w};
   wire [31:0] res_rd_w  = {24'h0, fmt_code(sar_q, fmt_sel)};
   wire [31:0] int_rd_w  = {29'h0, int_stat_q};
   wire [31:0] msk_rd_w  = {29'h0, int_mask_q};

   wire [31:0] rd_data_w = hit_ctrl_w ? ctrl_rd_w :
                           hit_stat_w ? stat_rd_w :
                           hit_res_w  ? res_rd_w  :
                           hit_int_w  ? int_rd_w  :
                           hit_msk_w  ? msk_rd_w  : 32'h0;

   // Set wins over a same-cycle write-one-to-clear
   generate
      for (gi = 0; gi < NUM_EV; gi = gi + 1) begin : g_int
         assign int_stat_d[gi] = ev_w[gi] | (int_stat_q[gi] & ~(w1c_w & pwdata[gi]));
      end
   endgenerate

   wire irq_d_w = |(int_stat_d & int_mask_q);

   // Answer in the first access cycle: no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup_w;
         prdata_q  <= (setup_w & ~pwrite) ? rd_data_w : 32'h0;
         pslverr_q <= setup_w & ~mapped_w;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_en_q   <= PIN_EN_RST;
         sw_start_q <= 1'b0;
         int_mask_q <= INT_MASK_RST;
      end else begin
         sw_start_q <= wr_w & hit_ctrl_w & pwdata[CTRL_START];
         if (wr_w & hit_ctrl_w) begin
            pin_en_q <= pwdata[CTRL_PIN_EN];
         end
         if (wr_w & hit_msk_w) begin
            int_mask_q <= pwdata[NUM_EV-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_q <= '0;
         irq_q      <= 1'b0;
      end else begin
         int_stat_q <= int_stat_d;
         irq_q      <= irq_d_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
   assign irq         = irq_q;
   assign dac_code    = sar_q;
   assign result_bus  = result_q;
   assign result_oe   = result_oe_q;
   assign done_flag_n = done_n_q;
endmodule : sacb_top

//--- tb/sacb_host_model.sv
// Host-side model: conversion clock and comparator decision
`timescale 1ns/1ps
module sacb_host_model (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        run,
   input  wire logic [sacb_pkg::DATA_W-1:0] target,
   input  wire logic [sacb_pkg::DATA_W-1:0] dac_code,
   output logic                             conv_clk,
   output logic                             compare_in
);
   import sacb_pkg::*;
   logic [1:0] ph_q;
   ////////////////////////////////////////
   // Input above the trial code sets the bit
   assign compare_in = (target > dac_code);
   // Three pclk a phase; parks only when low, so no phase is cut short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_q     <= 2'h0;
         conv_clk <= 1'b0;
      end else if (run || conv_clk) begin
         ph_q     <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
         conv_clk <= (ph_q == 2'h2) ? ~conv_clk : conv_clk;
      end
   end
endmodule : sacb_host_model

//--- tb/sacb_assertions.sv
// Concurrent checks on the pin port and APB port
`timescale 1ns/1ps
module sacb_checker (
   input wire logic                        pclk,
   input wire logic                        presetn,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [sacb_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0]                 pwdata,
   input wire logic [31:0]                 prdata,
   input wire logic                        pready,
   input wire logic                        pslverr,
   input wire logic                        conv_clk,
   input wire logic                        unit_enable_n,
   input wire logic                        begin_n,
   input wire logic                        fetch_n,
   input wire logic                        output_format_select,
   input wire logic [sacb_pkg::DATA_W-1:0] dac_code,
   input wire logic [sacb_pkg::DATA_W-1:0] result_bus,
   input wire logic                        result_oe,
   input wire logic                        done_flag_n
);
   import sacb_pkg::*;
   logic       clk_q;
   logic [3:0] rise_cnt_q;
   logic [3:0] rise_cnt_d;
   // Software start: the start bit written to the control word
   wire        sw_go_w = psel & penable & pready & pwrite & (paddr == OFF_CTRL)
                         & pwdata[CTRL_START];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   // Raw clock rises since the begin strobe or the software start
   assign rise_cnt_d = (!begin_n || sw_go_w) ? 4'h0 : rise_cnt_q + {3'h0, conv_clk & ~clk_q};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_q      <= 1'b0;
         rise_cnt_q <= 4'h0;
      end else begin
         clk_q      <= conv_clk;
         rise_cnt_q <= rise_cnt_d;
      end
   end
   ////////////////////////////////////////
   a_oe_cause: assert property (
      result_oe |-> $past(fetch_n, 2) == 1'b0 && $past(unit_enable_n, 2) == 1'b0)
      else $error("outputs enabled without both strobes");
   a_oe_enable: assert property (
      (!fetch_n && !unit_enable_n)[*3] |-> result_oe)
      else $error("outputs not enabled on read");
   a_format_code: assert property (
      ($stable(output_format_select) && $stable(dac_code))[*3]
      |-> result_bus == (dac_code ^ {!output_format_select, 7'h00}))
      else $error("result format wrong");
   a_clear_cause: assert property (
      $rose(done_flag_n) |-> dac_code == SAR_CLEAR && ($past(sw_go_w, 2)
      || $past(begin_n, 2) == 1'b0 && $past(unit_enable_n, 2) == 1'b0
      && $past(conv_clk, 2) == 1'b0))
      else $error("clear without begin, enable and clock low");
   a_done_holds: assert property (
      !done_flag_n && begin_n && $past(begin_n) && !$past(sw_go_w) |=> !done_flag_n)
      else $error("done flag lost without a clear");
   a_busy_high: assert property (
      $rose(done_flag_n) |-> done_flag_n[*8])
      else $error("done flag fell too early");
   a_first_trial: assert property (
      !begin_n && !unit_enable_n && !conv_clk ##1 begin_n |-> ##2 dac_code == SAR_FIRST)
      else $error("first trial code wrong");
   a_nine_rises: assert property (
      $fell(done_flag_n) |-> rise_cnt_q == 4'h9)
      else $error("done after wrong count of clock rises");
   a_ready_pulse: assert property (
      psel && !penable |=> pready ##1 !pready)
      else $error("ready not a one cycle answer");
   a_idle_quiet: assert property (
      !pready |-> !pslverr && prdata == 32'h0)
      else $error("response outside access cycle");
endmodule : sacb_checker

bind sacb_top sacb_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .conv_clk, .unit_enable_n, .begin_n, .fetch_n,
   .output_format_select, .dac_code, .result_bus, .result_oe, .done_flag_n);

//--- tb/testbench.sv
// Self-checking bench of the converter control and bus port
`timescale 1ns/1ps
module testbench;
   import sacb_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, tgt = 8'h00, dac_code, result_bus;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        unit_enable_n = 1'b1, begin_n = 1'b1, fetch_n = 1'b1, fmt = 1'b1, run = 1'b0;
   logic        pready, pslverr, irq, conv_clk, compare_in, result_oe, done_flag_n, er;
   int          err_total = 0, cmp_count = 0, cyc = 0;
   // Rows: format select, input level, expected code
   logic [16:0] rows [4] = '{17'h1a5a5, 17'h0a525, 17'h10000, 17'h0ff7f};
   always #2 pclk = ~pclk;
   sacb_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .irq, .conv_clk, .unit_enable_n, .begin_n, .fetch_n,
      .output_format_select(fmt), .compare_in, .dac_code, .result_bus, .result_oe,
      .done_flag_n);
   sacb_host_model u_host (.pclk, .presetn, .run, .target(tgt), .dac_code, .conv_clk,
      .compare_in);
   ////////////////////////////////////////
   task automatic finish_test;
      if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Waits on pready, never on a fixed count
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic start(input logic [7:0] t);
      run <= 1'b0;
      repeat (8) @(posedge pclk);
      tgt <= t;
      unit_enable_n <= 1'b0;
      begin_n <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(dac_code, SAR_CLEAR);
      chk(done_flag_n, 1'b1);
      begin_n <= 1'b1;
      run <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(dac_code, SAR_FIRST);
   endtask : start
   task automatic drain(input logic [7:0] exp);
      for (int i = 0; i < 300 && done_flag_n !== 1'b0; i++) @(posedge pclk);
      run <= 1'b0;
      chk(done_flag_n, 1'b0);
      chk(dac_code, tgt);
      fetch_n <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(result_oe, 1'b1);
      chk(result_bus, exp);
      fetch_n <= 1'b1;
      unit_enable_n <= 1'b1;
      apb(1'b0, OFF_RESULT, 32'h0);
      chk(rd[7:0], exp);
   endtask : drain
   ////////////////////////////////////////
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 8000) begin
         err_total++;
         finish_test();
      end
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk(done_flag_n, 1'b1);
      chk(result_oe, 1'b0);
      chk(irq, 1'b0);
      for (int i = 0; i < 4; i++) begin
         fmt <= rows[i][16];
         start(rows[i][15:8]);
         drain(rows[i][7:0]);
      end
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(rd[15:0], 16'hff02);
      apb(1'b0, OFF_INT_STAT, 32'h0);
      chk(rd[2:0], 3'h5);
      chk(irq, 1'b0);
      apb(1'b1, OFF_INT_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      apb(1'b1, OFF_INT_STAT, 32'h1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      apb(1'b0, OFF_INT_STAT, 32'h0);
      chk(rd[2:0], 3'h4);
      apb(1'b0, 8'h40, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      // Strobes without unit enable do nothing
      begin_n <= 1'b0;
      fetch_n <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(done_flag_n, 1'b0);
      chk(result_oe, 1'b0);
      begin_n <= 1'b1;
      fetch_n <= 1'b1;
      fmt <= 1'b1;
      start(8'h3c);
      repeat (20) @(posedge pclk);
      start(8'h3c);
      drain(8'h3c);
      apb(1'b0, OFF_INT_STAT, 32'h0);
      chk(rd[1], 1'b1);
      // Software start through the control word, begin_n left high
      tgt <= 8'hc3;
      unit_enable_n <= 1'b0;
      apb(1'b1, OFF_CTRL, 32'h3);
      run <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(done_flag_n, 1'b1);
      drain(8'hc3);
      apb(1'b0, OFF_CTRL, 32'h0);
      chk(rd, 32'h2);
      // Reset from the done state, then a fresh conversion
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({dac_code, result_bus, result_oe, done_flag_n, irq}, 19'h00002);
      presetn <= 1'b1;
      apb(1'b0, OFF_INT_MASK, 32'h0);
      chk(rd, 32'h0);
      start(8'h81);
      drain(8'h81);
      finish_test();
   end
endmodule : testbench
